// ===== fkl_pkg.sv
// Constants and types shared by the flash key-lock sequencer and its controller.
// Assumes one 25 MHz clock and a synchronous active-high reset everywhere.
// Function
// - Key register needs 0xA5 then 0xF1
// - Any delay allowed between the two keys
// - Wrong or misordered key locks until reset
// - Operation before full key locks until reset
// - Lock closes again after each operation
// - Write enable routes external writes to flash
// - Write enable clears only by software
// - Byte write stores old AND new data
// - Erase sets whole 512-byte page to 0xFF
// - Software should erase before programming
// - Set bank select before erasing banked page
// - Set timing extend before enables and keys
// - Erase enable, then write enable, then keys
// - Enabled keyed write anywhere erases its page
// - Software clears both enables after erase
// - Erase needs both enables set
// - Erase enable clear means single byte program
package fkl_pkg;
  localparam int FKL_ADDR_W = 16;
  localparam int FKL_BANK_W = 2;
  localparam int FKL_PAGE_BYTES = 512;
  localparam int FKL_OFF_W = 9;
  // Kept small so a simulation can hold the array; real parts are larger
  localparam int FKL_PAGES = 4;
  localparam int FKL_MEM_W = FKL_BANK_W + FKL_ADDR_W;
  localparam logic [7:0] FKL_KEY_FIRST = 8'hA5;
  localparam logic [7:0] FKL_KEY_SECOND = 8'hF1;
  localparam logic [7:0] FKL_ERASED = 8'hFF;
  localparam logic [7:0] FKL_CTRL_RESET = 8'h00;
  // Control register bit positions
  localparam int FKL_CTRL_WE_BIT = 0;
  localparam int FKL_CTRL_EE_BIT = 1;
  localparam int FKL_CTRL_TE_BIT = 2;
  localparam int FKL_CTRL_BANK_LSB = 4;
  // Controller register byte addresses on Wishbone
  localparam logic [3:0] FKL_REG_CTRL = 4'h0;
  localparam logic [3:0] FKL_REG_KEY = 4'h4;
  localparam logic [3:0] FKL_REG_ADDR = 4'h8;
  localparam logic [3:0] FKL_REG_DATA = 4'hC;
  localparam int FKL_ERASE_CYCLES = FKL_PAGE_BYTES;
  typedef enum logic [1:0] {FKL_KEY_IDLE, FKL_KEY_HALF, FKL_KEY_OPEN, FKL_KEY_DEAD} fkl_key_e;
endpackage : fkl_pkg

// ===== fkl_if.sv
// Carrier between the processor-side controller and the flash sequencer.
// Assumes both ends share clk_i; all signals are same-domain logic.
interface fkl_if;
  import fkl_pkg::*;
  logic ctrl_we;
  logic [7:0] ctrl_wdata;
  logic key_we;
  logic [7:0] key_wdata;
  logic xmw_valid;
  logic [FKL_ADDR_W-1:0] xmw_addr;
  logic [7:0] xmw_data;
  logic busy;
  logic [7:0] ctrl_rdata;
  logic [1:0] key_state;
  modport proc (output ctrl_we, ctrl_wdata, key_we, key_wdata, xmw_valid, xmw_addr, xmw_data,
                input busy, ctrl_rdata, key_state);
  modport dev (input ctrl_we, ctrl_wdata, key_we, key_wdata, xmw_valid, xmw_addr, xmw_data,
               output busy, ctrl_rdata, key_state);
endinterface : fkl_if

// ===== fkl_flash_array.sv
// Flash storage model: AND-programming of bytes and page erase to 0xFF.
// Assumes the sequencer issues one command at a time and waits on done.
module fkl_flash_array
  import fkl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic prog_i,
  input wire logic erase_i,
  input wire logic [FKL_MEM_W-1:0] addr_i,
  input wire logic [7:0] data_i,
  output logic done_o
);
  logic [7:0] mem_r [FKL_PAGES*FKL_PAGE_BYTES];
  logic erasing_r;
  logic [FKL_OFF_W-1:0] ecnt_r;
  logic [FKL_MEM_W-1:0] page_r;
  localparam int IDX_W = $clog2(FKL_PAGES*FKL_PAGE_BYTES);

  function automatic logic [IDX_W-1:0] idx(input logic [FKL_MEM_W-1:0] a);
    return a[IDX_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////
  // Storage: array content survives reset, like real flash
  always_ff @(posedge clk_i) begin
    if (prog_i) begin
      mem_r[idx(addr_i)] <= mem_r[idx(addr_i)] & data_i;
    end else if (erasing_r) begin
      mem_r[idx({page_r[FKL_MEM_W-1:FKL_OFF_W], ecnt_r})] <= FKL_ERASED;
    end
  end

  // Erase walks the page one byte per cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erasing_r <= 1'b0;
      ecnt_r <= '0;
      page_r <= '0;
    end else if (erase_i) begin
      erasing_r <= 1'b1;
      ecnt_r <= '0;
      page_r <= addr_i;
    end else if (erasing_r) begin
      ecnt_r <= ecnt_r + 1'b1;
      if (ecnt_r == FKL_OFF_W'(FKL_ERASE_CYCLES - 1)) begin
        erasing_r <= 1'b0;
      end
    end
  end

  // Done pulses after a program or the last erase byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= prog_i || (erasing_r && ecnt_r == FKL_OFF_W'(FKL_ERASE_CYCLES - 1));
    end
  end
endmodule : fkl_flash_array

// ===== fkl_device.sv
// Flash key-lock sequencer: control bits, key lock, and write routing to flash.
// Assumes the controller writes via fkl_if and waits while busy is high.
//
// The Wishbone register port and the address map were left to the implementer.
module fkl_device
  import fkl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  fkl_if.dev bus,
  output logic xram_we_o,
  output logic [FKL_ADDR_W-1:0] xram_addr_o,
  output logic [7:0] xram_data_o,
  output logic locked_out_o
);
  logic [7:0] ctrl_r;
  fkl_key_e key_r;
  logic busy_r;
  logic prog_r;
  logic erase_r;
  logic [FKL_MEM_W-1:0] faddr_r;
  logic [7:0] fdata_r;
  logic done;
  logic we_bit;
  logic ee_bit;
  logic fire;

  assign we_bit = ctrl_r[FKL_CTRL_WE_BIT];
  assign ee_bit = ctrl_r[FKL_CTRL_EE_BIT];
  assign fire = bus.xmw_valid && we_bit && !busy_r;
  assign bus.busy = busy_r;
  assign bus.ctrl_rdata = ctrl_r;
  assign bus.key_state = key_r;

  ////////////////////////////////////////////////////////////////
  // Control register: changes only on software writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= FKL_CTRL_RESET;
    end else if (bus.ctrl_we) begin
      ctrl_r <= bus.ctrl_wdata;
    end
  end

  // Key lock; dead state only leaves through reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_r <= FKL_KEY_IDLE;
    end else begin
      unique case (key_r)
        FKL_KEY_IDLE: begin
          if (fire) key_r <= FKL_KEY_DEAD;
          else if (bus.key_we) key_r <= (bus.key_wdata == FKL_KEY_FIRST) ? FKL_KEY_HALF : FKL_KEY_DEAD;
        end
        FKL_KEY_HALF: begin
          // No timeout here: the second key may come any time later
          if (fire) key_r <= FKL_KEY_DEAD;
          else if (bus.key_we) key_r <= (bus.key_wdata == FKL_KEY_SECOND) ? FKL_KEY_OPEN : FKL_KEY_DEAD;
        end
        FKL_KEY_OPEN: begin
          if (fire) key_r <= FKL_KEY_IDLE;
          else if (bus.key_we) key_r <= FKL_KEY_DEAD;
        end
        FKL_KEY_DEAD: key_r <= FKL_KEY_DEAD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Flash command issue; closed lock leaves flash untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      prog_r <= 1'b0;
      erase_r <= 1'b0;
      faddr_r <= '0;
      fdata_r <= '0;
    end else begin
      prog_r <= 1'b0;
      erase_r <= 1'b0;
      if (fire && key_r == FKL_KEY_OPEN) begin
        busy_r <= 1'b1;
        faddr_r <= {ctrl_r[FKL_CTRL_BANK_LSB +: FKL_BANK_W], bus.xmw_addr};
        fdata_r <= bus.xmw_data;
        erase_r <= ee_bit;
        prog_r <= !ee_bit;
      end else if (done) begin
        busy_r <= 1'b0;
      end
    end
  end

  // External-data path when write enable is clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xram_we_o <= 1'b0;
      xram_addr_o <= '0;
      xram_data_o <= '0;
    end else begin
      xram_we_o <= bus.xmw_valid && !we_bit;
      xram_addr_o <= bus.xmw_addr;
      xram_data_o <= bus.xmw_data;
    end
  end

  // Sticky lockout indication
  always_ff @(posedge clk_i) begin
    if (rst_i) locked_out_o <= 1'b0;
    else locked_out_o <= (key_r == FKL_KEY_DEAD);
  end

  fkl_flash_array u_array (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .prog_i(prog_r),
    .erase_i(erase_r),
    .addr_i(faddr_r),
    .data_i(fdata_r),
    .done_o(done)
  );
endmodule : fkl_device

// ===== fkl_proc.sv
// Processor-side controller: classic Wishbone slave turning writes into lock-interface actions.
// Assumes software orders control, keys and writes as the erase and write procedures want.
module fkl_proc
  import fkl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  fkl_if.proc bus
);
  logic [FKL_ADDR_W-1:0] addr_r;
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  ////////////////////////////////////////////////////////////////
  // Ack one cycle after request; data writes wait out a busy flash
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      bus.ctrl_we <= 1'b0;
      bus.key_we <= 1'b0;
      bus.xmw_valid <= 1'b0;
      bus.ctrl_wdata <= '0;
      bus.key_wdata <= '0;
      bus.xmw_addr <= '0;
      bus.xmw_data <= '0;
      addr_r <= '0;
    end else begin
      bus.ctrl_we <= 1'b0;
      bus.key_we <= 1'b0;
      bus.xmw_valid <= 1'b0;
      wb_ack_o <= 1'b0;
      if (req && !(wb_we_i && wb_adr_i == FKL_REG_DATA && bus.busy)) begin
        wb_ack_o <= 1'b1;
        unique case (wb_adr_i)
          FKL_REG_CTRL: wb_dat_o <= {24'h000000, bus.ctrl_rdata};
          FKL_REG_KEY: wb_dat_o <= {30'h00000000, bus.key_state};
          FKL_REG_ADDR: wb_dat_o <= {16'h0000, addr_r};
          default: wb_dat_o <= {31'h00000000, bus.busy};
        endcase
        if (wb_we_i && wb_sel_i[0]) begin
          unique case (wb_adr_i)
            FKL_REG_CTRL: begin
              bus.ctrl_we <= 1'b1;
              bus.ctrl_wdata <= wb_dat_i[7:0];
            end
            FKL_REG_KEY: begin
              bus.key_we <= 1'b1;
              bus.key_wdata <= wb_dat_i[7:0];
            end
            FKL_REG_ADDR: addr_r <= wb_dat_i[FKL_ADDR_W-1:0];
            FKL_REG_DATA: begin
              bus.xmw_valid <= 1'b1;
              bus.xmw_addr <= addr_r;
              bus.xmw_data <= wb_dat_i[7:0];
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule : fkl_proc

// ===== fkl_properties.sv
// Checks on the link between the controller and the flash sequencer.
// Assumes one clock; instantiated beside the link interface.
module fkl_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctrl_we,
  input wire logic key_we,
  input wire logic [7:0] key_wdata,
  input wire logic xmw_valid,
  input wire logic busy,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [1:0] key_state
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////
  // Key sequence progress
  key_first_a: assert property (key_state == 2'h0 && key_we && key_wdata == 8'hA5 |=> key_state == 2'h1)
    else $error("first key not taken");
  key_open_a: assert property (key_state == 2'h1 && key_we && key_wdata == 8'hF1 |=> key_state == 2'h2)
    else $error("lock did not open");
  key_bad_a: assert property (key_state == 2'h1 && key_we && key_wdata != 8'hF1 |=> key_state == 2'h3)
    else $error("bad second key taken");
  // Lockout must hold; only reset ends it
  dead_hold_a: assert property (key_state == 2'h3 |=> (key_state == 2'h3) [*8])
    else $error("lockout released");
  early_op_a: assert property (!key_state[1] && xmw_valid && ctrl_rdata[0] |=> key_state == 2'h3)
    else $error("early write not locked");
  // Flash activity follows the lock and the enables
  closed_idle_a: assert property (xmw_valid && key_state != 2'h2 |=> !busy)
    else $error("closed lock started flash");
  erase_run_a: assert property (xmw_valid && key_state == 2'h2 && ctrl_rdata[1:0] == 2'h3
    |=> busy [*8] ##[1:600] !busy) else $error("erase not run");
  relock_a: assert property ($fell(busy) |-> key_state == 2'h0)
    else $error("no relock after operation");
  we_sticky_a: assert property (!ctrl_we |=> ctrl_rdata[0] == $past(ctrl_rdata[0]))
    else $error("write enable changed alone");
endmodule // fkl_properties

// ===== flash_key_lock_erase_write_tb.sv
// Bench: controller and sequencer joined by the link, driven over Wishbone.
// Assumes package, link, design ends and checker compiled first.
module flash_key_lock_erase_write_tb
  import fkl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dato, q;
  logic ack, xwe, lko;
  logic [15:0] xa, a;
  logic [7:0] xd, d, c;
  logic [7:0] m, w;
  logic [15:0] kp [4];
  logic [23:0] xlast = 24'h0;
  int failures = 0;
  int num_checks = 0;
  int nx = 0;
  fkl_if link ();
  fkl_proc u_fkl_proc (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .bus(link));
  fkl_device u_fkl_device (.clk_i(clk_i), .rst_i(rst_i), .bus(link), .xram_we_o(xwe),
    .xram_addr_o(xa), .xram_data_o(xd), .locked_out_o(lko));
  fkl_properties u_fkl_properties (.clk_i(clk_i), .rst_i(rst_i), .ctrl_we(link.ctrl_we),
    .key_we(link.key_we), .key_wdata(link.key_wdata), .xmw_valid(link.xmw_valid), .busy(link.busy),
    .ctrl_rdata(link.ctrl_rdata), .key_state(link.key_state));
  ////////////////////////////////////////////////
  // 25 MHz clock
  initial forever #20 clk_i = ~clk_i;
  // Record data-memory writes; pulses last one cycle only
  always @(posedge clk_i) if (xwe === 1'b1) begin
    nx <= nx + 1;
    xlast <= {xa, xd};
  end
  task automatic test_done;
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Classic cycle; waits for ack under a bound, no assumed latency
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 1000);
    if (n >= 1000) failures++;
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rst_seq;
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // Random gap between keys; only order and values matter
  task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
    wb(1'b1, FKL_REG_KEY, {24'h0, k1});
    repeat ($urandom_range(0, 15)) @(posedge clk_i);
    wb(1'b1, FKL_REG_KEY, {24'h0, k2});
  endtask
  task automatic poll;
    int n;
    n = 0;
    do begin
      wb(1'b0, FKL_REG_DATA, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 400);
    if (n >= 400) failures++;
  endtask
  function automatic logic [1:0] key_exp(input logic [7:0] k1, input logic [7:0] k2);
    return (k1 == FKL_KEY_FIRST && k2 == FKL_KEY_SECOND) ? 2'h2 : 2'h3;
  endfunction
  // Hang guard, far beyond one erase
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    test_done();
  end
  initial begin
    q = $urandom(32'he494);
    rst_seq();
    wb(1'b0, FKL_REG_CTRL, 32'h0);
    chk(q[7:0], FKL_CTRL_RESET);
    // Unmapped write must leave control alone
    wb(1'b1, 4'h2, 32'hFF);
    wb(1'b0, FKL_REG_CTRL, 32'h0);
    chk(q[7:0], FKL_CTRL_RESET);
    a = 16'($urandom);
    d = 8'($urandom);
    wb(1'b1, FKL_REG_ADDR, {16'h0, a});
    wb(1'b0, FKL_REG_ADDR, 32'h0);
    chk(q[15:0], a);
    wb(1'b1, FKL_REG_DATA, {24'h0, d});
    repeat (2) @(posedge clk_i);
    chk(nx, 1);
    chk(xlast, {a, d});
    // Erase, then program twice; the second program must AND into the first
    for (int i = 0; i < 3; i++) begin
      c = {2'h0, 2'($urandom), 4'h5} | (i == 0 ? 8'h02 : 8'h00);
      w = (i == 0) ? d : 8'($urandom);
      m = (i == 0) ? FKL_ERASED : (m & w);
      wb(1'b1, FKL_REG_CTRL, {24'h0, c & 8'hF4});
      wb(1'b1, FKL_REG_CTRL, {24'h0, c & 8'hF6});
      wb(1'b1, FKL_REG_CTRL, {24'h0, c});
      keys(FKL_KEY_FIRST, FKL_KEY_SECOND);
      wb(1'b0, FKL_REG_KEY, 32'h0);
      chk(q[1:0], 2'h2);
      wb(1'b1, FKL_REG_DATA, {24'h0, w});
      poll();
      chk(u_fkl_device.u_array.mem_r[a[10:0]], m);
      chk(u_fkl_device.u_array.mem_r[{a[10:1], ~a[0]}], FKL_ERASED);
      wb(1'b0, FKL_REG_KEY, 32'h0);
      chk(q[1:0], 2'h0);
      wb(1'b0, FKL_REG_CTRL, 32'h0);
      chk(q[7:0], c);
      chk(nx, 1);
      if (i == 0) wb(1'b1, FKL_REG_CTRL, 32'h0);
    end
    // Bad pairs lock out; the last pair is the good one
    for (int i = 0; i < 4; i++) begin
      c = 8'($urandom_range(0, 164));
      kp = '{{8'hA5, c}, {8'hF1, 8'hA5}, {c, 8'hF1}, {8'hA5, 8'hF1}};
      rst_seq();
      keys(kp[i][15:8], kp[i][7:0]);
      wb(1'b0, FKL_REG_KEY, 32'h0);
      chk(q[1:0], key_exp(kp[i][15:8], kp[i][7:0]));
      chk(lko, key_exp(kp[i][15:8], kp[i][7:0]) == 2'h3);
    end
    // Write before keys locks out; later keys and writes do nothing
    rst_seq();
    wb(1'b1, FKL_REG_CTRL, 32'h3);
    wb(1'b1, FKL_REG_DATA, 32'h0);
    keys(FKL_KEY_FIRST, FKL_KEY_SECOND);
    wb(1'b0, FKL_REG_KEY, 32'h0);
    chk(q[1:0], 2'h3);
    chk(lko, 1'b1);
    wb(1'b1, FKL_REG_DATA, 32'h0);
    wb(1'b0, FKL_REG_DATA, 32'h0);
    chk(q[0], 1'b0);
    chk(nx, 1);
    test_done();
  end
endmodule // flash_key_lock_erase_write_tb
